//--- inc/otpc_regs.svh
// Command codes, unlock prefix, identification address bits and bus timing of the OTP ROM
`ifndef OTPC_REGS_SVH
`define OTPC_REGS_SVH

// Unlock prefix, decoded on the low fifteen address lines only
`define OTPC_UNLOCK1_ADDR 15'h5555
`define OTPC_UNLOCK1_DATA 8'haa
`define OTPC_UNLOCK2_ADDR 15'h2aaa
`define OTPC_UNLOCK2_DATA 8'h55
`define OTPC_CMD_ADDR     15'h5555

// Third-cycle command codes
`define OTPC_CMD_READ_RESET 8'hf0
`define OTPC_CMD_ID_READ    8'h90
`define OTPC_CMD_PROGRAM    8'ha0
`define OTPC_CMD_STATUS     8'h70
`define OTPC_CMD_CLEAR      8'h50

// Identification address bits
`define OTPC_ID_A0_BIT 0
`define OTPC_ID_A1_BIT 1

// Clock rate and bus timing in ns
`define OTPC_CLK_MHZ    100
`define OTPC_T_ACC_NS   120
`define OTPC_T_PULSE_NS 100
`define OTPC_T_SETUP_NS 20
`define OTPC_T_HOLD_NS  20

// Least times round up to whole cycles
`define OTPC_NS2CYC(ns) ((((ns) * `OTPC_CLK_MHZ) + 999) / 1000)
`define OTPC_ACC_CYC    5'(`OTPC_NS2CYC(`OTPC_T_ACC_NS))
`define OTPC_PULSE_CYC  5'(`OTPC_NS2CYC(`OTPC_T_PULSE_NS))
`define OTPC_SETUP_CYC  5'(`OTPC_NS2CYC(`OTPC_T_SETUP_NS))
`define OTPC_HOLD_CYC   5'(`OTPC_NS2CYC(`OTPC_T_HOLD_NS))

`endif

//--- inc/otpc_pkg.sv
// Types shared by the OTP ROM host controller
package otpc_pkg;

  // Host operations
  typedef enum logic [2:0] {
    OP_ARRAY_READ = 3'h0,
    OP_RESET_READ = 3'h1,
    OP_ID_READ    = 3'h2,
    OP_PROGRAM    = 3'h3,
    OP_STATUS     = 3'h4,
    OP_CLEAR      = 3'h5,
    OP_HV_ID_READ = 3'h6
  } otpc_op_t;

  // Read path the device is believed to point at
  typedef enum logic [1:0] {
    MODE_ARRAY  = 2'h0,
    MODE_ID     = 2'h1,
    MODE_STATUS = 2'h2
  } otpc_mode_t;

  // Command sequencer states
  typedef enum logic [5:0] {
    SQ_IDLE  = 6'h01,
    SQ_UNLK1 = 6'h02,
    SQ_UNLK2 = 6'h04,
    SQ_CMD   = 6'h08,
    SQ_LAST  = 6'h10,
    SQ_DONE  = 6'h20
  } otpc_sq_t;

  // Bus cycle engine states
  typedef enum logic [4:0] {
    EN_IDLE   = 5'h01,
    EN_SETUP  = 5'h02,
    EN_STROBE = 5'h04,
    EN_HOLD   = 5'h08,
    EN_DONE   = 5'h10
  } otpc_en_t;

endpackage

//--- inc/otpc_cyc_if.sv
// One bus cycle request between sequencer and bus cycle engine
`timescale 1ns/1ns
interface otpc_cyc_if;
  logic        req;
  logic        wr;
  logic [19:0] addr;
  logic        lsb;
  logic [15:0] wdata;
  logic        byte_mode;
  logic        hv_id;
  logic        done;
  logic [15:0] rdata;

  modport seq (output req, wr, addr, lsb, wdata, byte_mode, hv_id,
               input done, rdata);
  modport eng (input req, wr, addr, lsb, wdata, byte_mode, hv_id,
               output done, rdata);
endinterface

//--- hdl/otpc_bus_engine.sv
// Bus cycle engine: one timed read or write cycle on the ROM pins
`timescale 1ns/1ns
`include "otpc_regs.svh"
module otpc_bus_engine (
  input  wire logic   i_clock,
  input  wire logic   i_sys_rst,
  input  wire logic   i_clk_en,
  otpc_cyc_if.eng     cyc,
  output logic [19:0] o_addr,
  output logic        o_ce_n,
  output logic        o_oe_n,
  output logic        o_word_sel,
  output logic        o_vpp_en,
  output logic        o_a9_hv,
  input  wire logic [14:0] i_q,
  output logic [14:0] o_q,
  output logic        o_q_oe,
  input  wire logic   i_top,
  output logic        o_top,
  output logic        o_top_oe
);

  otpc_pkg::otpc_en_t state, next_state;
  logic [4:0]  cnt, next_cnt;
  logic        wr, next_wr;
  logic [19:0] addr, next_addr;
  logic        lsb, next_lsb;
  logic [15:0] wdata, next_wdata;
  logic        bmode, next_bmode;
  logic        hv, next_hv;
  logic [15:0] rdata, next_rdata;

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic of the cycle
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_wr    = wr;
    next_addr  = addr;
    next_lsb   = lsb;
    next_wdata = wdata;
    next_bmode = bmode;
    next_hv    = hv;
    next_rdata = rdata;
    unique case (state)
      otpc_pkg::EN_IDLE: begin
        if (cyc.req) begin
          next_wr    = cyc.wr;
          next_addr  = cyc.addr;
          next_lsb   = cyc.lsb;
          next_wdata = cyc.wdata;
          next_bmode = cyc.byte_mode;
          next_hv    = cyc.hv_id;
          next_cnt   = `OTPC_SETUP_CYC;
          next_state = otpc_pkg::EN_SETUP;
        end
      end
      otpc_pkg::EN_SETUP: begin
        // Address settles before chip enable falls
        if (cnt <= 5'h01) begin
          next_cnt   = wr ? `OTPC_PULSE_CYC : `OTPC_ACC_CYC;
          next_state = otpc_pkg::EN_STROBE;
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      otpc_pkg::EN_STROBE: begin
        if (cnt <= 5'h01) begin
          // Sample only after full access time; upper byte idle in byte mode
          if (!wr) begin
            next_rdata = bmode ? {8'h00, i_q[7:0]} : {i_top, i_q};
          end
          next_cnt   = `OTPC_HOLD_CYC;
          next_state = otpc_pkg::EN_HOLD;
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      otpc_pkg::EN_HOLD: begin
        // Data stays on the pins past the rising chip enable
        if (cnt <= 5'h01) begin
          next_state = otpc_pkg::EN_DONE;
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      otpc_pkg::EN_DONE: begin
        next_state = otpc_pkg::EN_IDLE;
      end
    endcase
  end

  // Cycle registers; clock enable freezes everything
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= otpc_pkg::EN_IDLE;
      cnt   <= 5'h00;
      wr    <= 1'b0;
      addr  <= 20'h00000;
      lsb   <= 1'b0;
      wdata <= 16'h0000;
      bmode <= 1'b0;
      hv    <= 1'b0;
      rdata <= 16'h0000;
    end else if (i_clk_en) begin
      state <= next_state;
      cnt   <= next_cnt;
      wr    <= next_wr;
      addr  <= next_addr;
      lsb   <= next_lsb;
      wdata <= next_wdata;
      bmode <= next_bmode;
      hv    <= next_hv;
      rdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drive from registered state
  logic active;
  assign active     = (state != otpc_pkg::EN_IDLE);
  // Address latched by falling chip enable, data by rising edge
  assign o_ce_n     = (state != otpc_pkg::EN_STROBE);
  // Read strobe only on reads, held high through writes
  assign o_oe_n     = !(state == otpc_pkg::EN_STROBE && !wr);
  assign o_addr     = addr;
  assign o_word_sel = !bmode;
  assign o_vpp_en   = active && wr;
  assign o_a9_hv    = active && hv;
  // All fifteen low data pins driven for the whole write cycle
  assign o_q        = wdata[14:0];
  assign o_q_oe     = active && wr;
  // Top pin is the byte address in byte mode, data bit 15 on word writes
  assign o_top      = bmode ? lsb : wdata[15];
  assign o_top_oe   = bmode || (active && wr);
  assign cyc.done   = (state == otpc_pkg::EN_DONE);
  assign cyc.rdata  = rdata;

endmodule

//--- hdl/otpc_host.sv
// Host controller that issues command sequences and bus cycles to the ROM
`timescale 1ns/1ns
`include "otpc_regs.svh"
module otpc_host (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  input  wire logic        i_req,
  input  wire logic [2:0]  i_op,
  input  wire logic [19:0] i_addr,
  input  wire logic        i_byte_lsb,
  input  wire logic        i_byte_mode,
  input  wire logic [15:0] i_wdata,
  output logic             o_ready,
  output logic             o_done,
  output logic [15:0]      o_rdata,
  output logic [1:0]       o_read_mode,
  output logic [19:0]      o_addr,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_word_sel,
  output logic             o_vpp_en,
  output logic             o_a9_hv,
  input  wire logic [14:0] i_q,
  output logic [14:0]      o_q,
  output logic             o_q_oe,
  input  wire logic        i_top,
  output logic             o_top,
  output logic             o_top_oe
);

  otpc_cyc_if cyc ();

  otpc_pkg::otpc_sq_t   state, next_state;
  otpc_pkg::otpc_op_t   op, next_op;
  otpc_pkg::otpc_mode_t mode, next_mode;
  logic [19:0] addr, next_addr;
  logic        lsb, next_lsb;
  logic        bmode, next_bmode;
  logic [15:0] wdata, next_wdata;
  logic [15:0] rdata, next_rdata;
  logic        done, next_done;
  logic [7:0]  cmd_code;

  //////////////////////////////////////////////////////////////////////////
  // Third-cycle code for the held operation
  always_comb begin
    unique case (op)
      otpc_pkg::OP_RESET_READ: cmd_code = `OTPC_CMD_READ_RESET;
      otpc_pkg::OP_ID_READ:    cmd_code = `OTPC_CMD_ID_READ;
      otpc_pkg::OP_PROGRAM:    cmd_code = `OTPC_CMD_PROGRAM;
      otpc_pkg::OP_STATUS:     cmd_code = `OTPC_CMD_STATUS;
      otpc_pkg::OP_CLEAR:      cmd_code = `OTPC_CMD_CLEAR;
      default:                 cmd_code = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Cycle request per sequencer state
  always_comb begin
    cyc.req       = 1'b0;
    cyc.wr        = 1'b1;
    cyc.addr      = 20'h00000;
    cyc.lsb       = 1'b0;
    cyc.wdata     = 16'h0000;
    cyc.byte_mode = bmode;
    cyc.hv_id     = 1'b0;
    unique case (state)
      otpc_pkg::SQ_IDLE: begin
      end
      otpc_pkg::SQ_UNLK1: begin
        // Upper address lines held low; only A0..A14 count
        cyc.req   = 1'b1;
        cyc.addr  = {5'h00, `OTPC_UNLOCK1_ADDR};
        cyc.wdata = {8'h00, `OTPC_UNLOCK1_DATA};
      end
      otpc_pkg::SQ_UNLK2: begin
        cyc.req   = 1'b1;
        cyc.addr  = {5'h00, `OTPC_UNLOCK2_ADDR};
        cyc.wdata = {8'h00, `OTPC_UNLOCK2_DATA};
      end
      otpc_pkg::SQ_CMD: begin
        cyc.req   = 1'b1;
        cyc.addr  = {5'h00, `OTPC_CMD_ADDR};
        cyc.wdata = {8'h00, cmd_code};
      end
      otpc_pkg::SQ_LAST: begin
        // Last cycle, fourth after a prefix, only one for plain reads: program write, else a read at the user address, A0 only for high-voltage id
        cyc.req   = 1'b1;
        cyc.wr    = (op == otpc_pkg::OP_PROGRAM);
        cyc.addr  = addr;
        cyc.lsb   = lsb;
        cyc.wdata = wdata;
        if (op == otpc_pkg::OP_HV_ID_READ) begin
          // Codes chosen by A0 with A1 low while A9 sits at high voltage
          cyc.hv_id = 1'b1;
          cyc.addr  = 20'h00000;
          cyc.addr[`OTPC_ID_A0_BIT] = addr[`OTPC_ID_A0_BIT];
        end
      end
      otpc_pkg::SQ_DONE: begin
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    next_state = state;
    next_op    = op;
    next_mode  = mode;
    next_addr  = addr;
    next_lsb   = lsb;
    next_bmode = bmode;
    next_wdata = wdata;
    next_rdata = rdata;
    next_done  = 1'b0;
    unique case (state)
      otpc_pkg::SQ_IDLE: begin
        if (i_req) begin
          next_op    = otpc_pkg::otpc_op_t'(i_op);
          next_addr  = i_addr;
          next_lsb   = i_byte_lsb;
          next_bmode = i_byte_mode;
          next_wdata = i_wdata;
          // Plain reads need no prefix; the device starts in array read
          if (i_op == otpc_pkg::OP_ARRAY_READ ||
              i_op == otpc_pkg::OP_HV_ID_READ) begin
            next_state = otpc_pkg::SQ_LAST;
          end else begin
            next_state = otpc_pkg::SQ_UNLK1;
          end
        end
      end
      otpc_pkg::SQ_UNLK1: begin
        if (cyc.done) begin
          next_state = otpc_pkg::SQ_UNLK2;
        end
      end
      otpc_pkg::SQ_UNLK2: begin
        if (cyc.done) begin
          next_state = otpc_pkg::SQ_CMD;
        end
      end
      otpc_pkg::SQ_CMD: begin
        if (cyc.done) begin
          // Clear status ends after its third write
          if (op == otpc_pkg::OP_CLEAR) begin
            next_state = otpc_pkg::SQ_DONE;
          end else begin
            next_state = otpc_pkg::SQ_LAST;
          end
          // Track where the device read path now points
          unique case (op)
            otpc_pkg::OP_RESET_READ: next_mode = otpc_pkg::MODE_ARRAY;
            otpc_pkg::OP_ID_READ:    next_mode = otpc_pkg::MODE_ID;
            otpc_pkg::OP_PROGRAM:    next_mode = otpc_pkg::MODE_STATUS;
            otpc_pkg::OP_STATUS:     next_mode = otpc_pkg::MODE_STATUS;
            default:                 next_mode = mode;
          endcase
        end
      end
      otpc_pkg::SQ_LAST: begin
        if (cyc.done) begin
          next_rdata = (op == otpc_pkg::OP_PROGRAM) ? 16'h0000 : cyc.rdata;
          next_state = otpc_pkg::SQ_DONE;
        end
      end
      otpc_pkg::SQ_DONE: begin
        next_done  = 1'b1;
        next_state = otpc_pkg::SQ_IDLE;
      end
    endcase
  end

  // Sequencer registers; power-up view is array read
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= otpc_pkg::SQ_IDLE;
      op    <= otpc_pkg::OP_ARRAY_READ;
      mode  <= otpc_pkg::MODE_ARRAY;
      addr  <= 20'h00000;
      lsb   <= 1'b0;
      bmode <= 1'b0;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      done  <= 1'b0;
    end else if (i_clk_en) begin
      state <= next_state;
      op    <= next_op;
      mode  <= next_mode;
      addr  <= next_addr;
      lsb   <= next_lsb;
      bmode <= next_bmode;
      wdata <= next_wdata;
      rdata <= next_rdata;
      done  <= next_done;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // User side outputs
  assign o_ready     = (state == otpc_pkg::SQ_IDLE);
  assign o_done      = done;
  assign o_rdata     = rdata;
  assign o_read_mode = mode;

  // Pin timing lives in the engine
  otpc_bus_engine u_engine (
    .i_clock    (i_clock),
    .i_sys_rst  (i_sys_rst),
    .i_clk_en   (i_clk_en),
    .cyc        (cyc.eng),
    .o_addr     (o_addr),
    .o_ce_n     (o_ce_n),
    .o_oe_n     (o_oe_n),
    .o_word_sel (o_word_sel),
    .o_vpp_en   (o_vpp_en),
    .o_a9_hv    (o_a9_hv),
    .i_q        (i_q),
    .o_q        (o_q),
    .o_q_oe     (o_q_oe),
    .i_top      (i_top),
    .o_top      (o_top),
    .o_top_oe   (o_top_oe)
  );

endmodule

//--- bench/otpc_host_checker.sv
// Pin-level assertions on the OTP ROM host controller
`timescale 1ns/1ns
module otpc_host_checker (
  input wire logic        i_clock,
  input wire logic        i_sys_rst,
  input wire logic        i_req,
  input wire logic [2:0]  i_op,
  input wire logic        o_ready,
  input wire logic        o_done,
  input wire logic [1:0]  o_read_mode,
  input wire logic [19:0] o_addr,
  input wire logic        o_ce_n,
  input wire logic        o_oe_n,
  input wire logic        o_word_sel,
  input wire logic        o_a9_hv,
  input wire logic        o_vpp_en,
  input wire logic [14:0] o_q,
  input wire logic        o_q_oe,
  input wire logic        o_top_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Reset checked while reset is high, so it has no disable
  AST_RESET_IDLE: assert property (disable iff (1'b0) i_sys_rst |=>
    o_ce_n && o_oe_n && o_ready && !o_done && !o_q_oe &&
    o_read_mode == 2'h0) else $error("controller not idle after reset");
  AST_NO_CONTEND: assert property (!o_ce_n && !o_oe_n |-> !o_q_oe)
    else $error("host drives data during a read");
  AST_WR_LEVELS: assert property (o_q_oe |-> o_oe_n &&
    o_vpp_en) else $error("write without strobe high or supply");
  AST_ADDR_HOLD: assert property (!o_ce_n && !$past(o_ce_n) |->
    $stable(o_addr)) else $error("address moved under chip enable");
  AST_DATA_HOLD: assert property ($rose(o_ce_n) && o_q_oe |->
    $stable(o_q) ##1 (o_q_oe && $stable(o_q)))
    else $error("write data not held past chip enable rise");
  AST_WR_PULSE: assert property ($fell(o_ce_n) && o_oe_n |->
    (o_q_oe && !o_ce_n) [*8]) else $error("write pulse too short");
  AST_RD_STROBE: assert property ($fell(o_oe_n) |->
    (!o_ce_n && !o_oe_n) [*8]) else $error("read strobe too short");
  AST_READ_LAT: assert property (i_req && o_ready &&
    (i_op == 3'h0 || i_op == 3'h6) |-> (!o_q_oe) [*8] ##13 o_done)
    else $error("plain read not done in time or wrote");
  AST_HV_ADDR: assert property (o_a9_hv |->
    o_addr[19:1] == 19'h0 && !o_q_oe) else $error("id address not low");
  AST_BYTE_TOP: assert property (!o_word_sel |-> o_top_oe)
    else $error("byte address pin not driven");
  AST_WORD_TOP: assert property (o_word_sel && !o_oe_n |-> !o_top_oe)
    else $error("top data pin driven in a word read");
  AST_MODE_KEEP: assert property (o_ready && !i_req |=>
    $stable(o_read_mode)) else $error("read mode changed while idle");

  // Main scenarios
  CV_PROG: cover property (i_req && o_ready && i_op == 3'h3);
  CV_BYTE: cover property (!o_word_sel && !o_oe_n);
  CV_HVID: cover property (o_a9_hv && !o_oe_n);
endmodule

bind otpc_host otpc_host_checker u_chk (.i_clock, .i_sys_rst, .i_req,
  .i_op, .o_ready, .o_done, .o_read_mode, .o_addr, .o_ce_n, .o_oe_n,
  .o_word_sel, .o_a9_hv, .o_vpp_en, .o_q, .o_q_oe, .o_top_oe);

//--- bench/otpc_rom_model.sv
// Behavioural model of the OTP ROM facing the host controller
`timescale 1ns/1ns
module otpc_rom_model #(
  parameter logic [7:0] MFR_CODE = 8'h3c,  // Arbitrary maker code
  parameter logic [7:0] DEV_CODE = 8'h41   // Arbitrary part code
) (
  input  wire logic        i_clock,
  input  wire logic [19:0] i_addr,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_word_sel,
  input  wire logic        i_vpp_en,
  input  wire logic        i_a9_hv,
  input  wire logic [14:0] i_q,
  input  wire logic        i_top,
  output logic [14:0]      o_q,
  output logic             o_top,
  output logic [7:0]       o_clears
);
  logic [15:0] mem [int];
  logic [19:0] lat_a;
  logic [1:0]  mode = 2'h0;  // Powers up in array read
  logic        prog = 1'b0;
  logic        tgl = 1'b0;
  logic [15:0] word;
  logic [7:0]  cmd;
  int          step = 0;

  initial o_clears = 8'h0;
  // Released lines wander so stale data never looks valid
  always @(posedge i_clock) tgl <= ~tgl;
  // Address latched on falling chip enable
  always @(negedge i_ce_n) lat_a = i_addr;
  ////////////////////////////////////////////////////////////////////////////
  // Command latch, data taken on rising chip enable
  always @(posedge i_ce_n) begin
    if (i_oe_n === 1'b1 && i_vpp_en === 1'b1) begin
      cmd = i_q[7:0];
      if (prog) begin
        mem[lat_a] = {i_top, i_q};
        prog = 1'b0;  // Sequencer ends at once, status stays
      end else if (step == 0 && lat_a[14:0] == 15'h5555 && cmd == 8'haa)
        step = 1;
      else if (step == 1 && lat_a[14:0] == 15'h2aaa && cmd == 8'h55)
        step = 2;
      else if (step == 2 && lat_a[14:0] == 15'h5555) begin
        step = 0;
        case (cmd)
          8'hf0: mode = 2'h0;
          8'h90: mode = 2'h1;
          8'h70: mode = 2'h2;
          8'ha0: begin
            prog = 1'b1;
            mode = 2'h2;
          end
          8'h50: o_clears = o_clears + 8'h1;
          default: ;
        endcase
      end else step = 0;  // Stray cycle drops the prefix
    end
  end
  // Read path and output gating
  always @* begin
    if (i_a9_hv === 1'b1 || mode == 2'h1)
      word = {8'h00, i_addr[0] ? DEV_CODE : MFR_CODE};
    else if (mode == 2'h2) word = 16'h0080;
    else if (mem.exists(i_addr)) word = mem[i_addr];
    else word = i_addr[15:0] ^ 16'h5a3c;
    o_q = {15{tgl}};
    o_top = tgl;
    if (!i_ce_n && !i_oe_n) begin
      if (i_word_sel) {o_top, o_q} = word;
      else o_q[7:0] = i_top ? word[15:8] : word[7:0];
    end
  end
endmodule

//--- bench/otpc_host_tb.sv
// Self-checking bench of the OTP ROM host controller
`timescale 1ns/1ns
module otpc_host_tb;
  localparam logic [7:0] MFR = 8'h3c;  // Arbitrary maker code
  localparam logic [7:0] DEV = 8'h41;  // Arbitrary part code
  logic        i_clock = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_clk_en = 1'b1;
  logic        i_req = 1'b0;
  logic [2:0]  i_op = 3'h0;
  logic [19:0] i_addr = 20'h0;
  logic        i_byte_lsb = 1'b0;
  logic        i_byte_mode = 1'b0;
  logic [15:0] i_wdata = 16'h0;
  logic        o_ready, o_done, o_ce_n, o_oe_n, o_word_sel, o_vpp_en;
  logic        o_a9_hv, o_q_oe, o_top, o_top_oe, rom_top;
  logic [15:0] o_rdata;
  logic [1:0]  o_read_mode;
  logic [19:0] o_addr;
  logic [14:0] o_q, rom_q;
  logic [7:0]  clears, c0;
  int          bad_count = 0;
  int          checks = 0;
  // Shared pins: whoever enables drives
  wire  [14:0] q_bus = o_q_oe ? o_q : rom_q;
  wire         top_bus = o_top_oe ? o_top : rom_top;

  always #5 i_clock = ~i_clock;

  otpc_host uut (.i_clock, .i_sys_rst, .i_clk_en, .i_req, .i_op,
    .i_addr, .i_byte_lsb, .i_byte_mode, .i_wdata, .o_ready, .o_done,
    .o_rdata, .o_read_mode, .o_addr, .o_ce_n, .o_oe_n, .o_word_sel,
    .o_vpp_en, .o_a9_hv, .i_q(q_bus), .o_q, .o_q_oe, .i_top(top_bus),
    .o_top, .o_top_oe);
  otpc_rom_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) rom (.i_clock,
    .i_addr(o_addr), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n),
    .i_word_sel(o_word_sel), .i_vpp_en(o_vpp_en), .i_a9_hv(o_a9_hv),
    .i_q(q_bus), .i_top(top_bus), .o_q(rom_q), .o_top(rom_top),
    .o_clears(clears));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Unprogrammed array contents of the model
  function automatic logic [15:0] arr(input logic [19:0] a);
    return a[15:0] ^ 16'h5a3c;
  endfunction
  // One operation, bounded wait on its done pulse
  task automatic op(input logic [2:0] o, input logic [19:0] a,
                    input logic bm, input logic lsb, input logic [15:0] wd);
    int n;
    @(posedge i_clock);
    i_req <= 1'b1;
    i_op <= o;
    i_addr <= a;
    i_byte_mode <= bm;
    i_byte_lsb <= lsb;
    i_wdata <= wd;
    @(posedge i_clock);
    i_req <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while (o_done !== 1'b1 && n < 200);
    if (n >= 200) cmp("done", 16'h1, 16'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Plain reads straight after reset, word and byte
  task automatic t_plain();
    op(3'h0, 20'hf8123, 1'b0, 1'b0, 16'h0);
    cmp("word read", arr(20'hf8123), o_rdata);
    cmp("mode", 16'h0, {14'h0, o_read_mode});
    op(3'h0, 20'h00456, 1'b1, 1'b0, 16'h0);
    cmp("low byte", arr(20'h00456) & 16'h00ff, o_rdata);
    op(3'h0, 20'h00456, 1'b1, 1'b1, 16'h0);
    cmp("high byte", arr(20'h00456) >> 8, o_rdata);
  endtask
  // High-voltage identification on both codes
  task automatic t_hv_id();
    op(3'h6, 20'h00000, 1'b0, 1'b0, 16'h0);
    cmp("hv maker", {8'h00, MFR}, o_rdata);
    op(3'h6, 20'h00001, 1'b0, 1'b0, 16'h0);
    cmp("hv part", {8'h00, DEV}, o_rdata);
  endtask
  // Command identification, then the path stays until read/reset
  task automatic t_cmd_id();
    op(3'h2, 20'h00000, 1'b0, 1'b0, 16'h0);
    cmp("cmd maker", {8'h00, MFR}, o_rdata);
    cmp("mode", 16'h1, {14'h0, o_read_mode});
    op(3'h2, 20'h00001, 1'b0, 1'b0, 16'h0);
    cmp("cmd part", {8'h00, DEV}, o_rdata);
    op(3'h0, 20'h00001, 1'b0, 1'b0, 16'h0);
    cmp("id path kept", {8'h00, DEV}, o_rdata);
    op(3'h1, 20'h00321, 1'b0, 1'b0, 16'h0);
    cmp("reset read", arr(20'h00321), o_rdata);
    cmp("mode", 16'h0, {14'h0, o_read_mode});
  endtask
  // Program with upper address set, status until a new command
  task automatic t_program();
    op(3'h3, 20'h4a010, 1'b0, 1'b0, 16'hbeef);
    cmp("mode", 16'h2, {14'h0, o_read_mode});
    op(3'h0, 20'h00777, 1'b0, 1'b0, 16'h0);
    cmp("status after program", 16'h0080, o_rdata);
    op(3'h1, 20'h4a010, 1'b0, 1'b0, 16'h0);
    cmp("programmed word", 16'hbeef, o_rdata);
  endtask
  // Status read in byte mode, then clear in three writes
  task automatic t_status();
    op(3'h4, 20'h12345, 1'b1, 1'b0, 16'h0);
    cmp("status", 16'h0080, o_rdata);
    c0 = clears;
    op(3'h5, 20'h00000, 1'b0, 1'b0, 16'h0);
    cmp("clears", {8'h00, c0 + 8'h1}, {8'h00, clears});
    cmp("mode", 16'h2, {14'h0, o_read_mode});
    op(3'h0, 20'h00010, 1'b0, 1'b0, 16'h0);
    cmp("status kept", 16'h0080, o_rdata);
    op(3'h1, 20'h00010, 1'b0, 1'b0, 16'h0);
    cmp("array again", arr(20'h00010), o_rdata);
  endtask
  // Clock enable low inside a write strobe freezes the pins, then resumes
  task automatic t_freeze();
    fork
      op(3'h1, 20'h00abc, 1'b0, 1'b0, 16'h0);
      begin
        repeat (6) @(posedge i_clock);
        i_clk_en <= 1'b0;
        repeat (30) @(posedge i_clock);
        #1;
        cmp("frozen strobe", 16'h0, {15'h0, o_ce_n});
        cmp("frozen data", 16'h1, {15'h0, o_q_oe});
        @(posedge i_clock);
        i_clk_en <= 1'b1;
      end
    join
    cmp("read after freeze", arr(20'h00abc), o_rdata);
  endtask

  initial begin
    repeat (12) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_plain();
    t_hv_id();
    t_cmd_id();
    t_program();
    t_status();
    t_freeze();
    wrap_up();
  end
  // Whole run needs about 800 cycles
  initial begin
    repeat (20000) @(posedge i_clock);
    bad_count++;
    wrap_up();
  end
endmodule
